/* rtl/dio_top.v */
// Behaviour
// [R1] Every digital output has its own selection code choosing its function.
// [R2] Code 0x16 shows capture completed.
// [R3] Code 0x17 shows data set completed AND movement completed.
// [R4] Code 0x19 shows velocity within speed window of target.
// [R5] Codes 0x30..0x37 route soft output word bit n.
// [R6] Pause acts only in pulse-train mode.
// [R7] Active pause decelerates along the stop ramp.
// [R8] Released pause resumes from the interrupted position.
// [R9] Pulses during pause are discarded, not counted into target.
// [R10] After pause release, ongoing pulses are accepted and followed.
// [R11] Controller keeps pause until motor stopped, else rehomes.
// [R12] Operational stop decelerates along a ramp to standstill.
// [R13] Pause and operational stop share one stop ramp setting.
// [R14] Operational stop disables power at standstill, then brake if configured; the code drops power_enable and sets brake_apply on the same clock edge.
// [R15] Operational stop reports a dedicated error code.
// [R16] Controller releases stop input, then re-enables the power stage.
// [R17] Pause and stop inputs must be assigned before use.
// [R18] Data-set-completed asserts after data set and waiting time finish.
// [R19] In pulse-train mode movement completed needs tolerance and standstill.
// [R20] Reserved selection codes hold the output inactive.
// [R21] Outputs follow the selected function each cycle without filtering.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "dio_defines.vh"
module dio_top #(
  parameter NOUT = 5,
  parameter VW = 16
) (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  pause_in,
  op_stop_in,
  pulse_step,
  pulse_dir,
  capture_ok,
  data_set_done,
  pos_in_tol,
  velocity,
  target_velocity,
  dout,
  speed_cmd,
  target_pos,
  power_enable,
  brake_apply,
  op_stop_error_code
);
  input wire pclk;
  input wire presetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  input wire pause_in;
  input wire op_stop_in;
  input wire pulse_step;
  input wire pulse_dir;
  input wire capture_ok;
  input wire data_set_done;
  input wire pos_in_tol;
  input wire [VW-1:0] velocity;
  input wire [VW-1:0] target_velocity;
  output reg [NOUT-1:0] dout;
  output reg [VW-1:0] speed_cmd;
  output reg [31:0] target_pos;
  output reg power_enable;
  output reg brake_apply;
  output reg [7:0] op_stop_error_code;

  reg [8*NOUT-1:0] sel_ff;
  reg [7:0] soft_output_word_ff;
  reg pulse_mode_ff;
  reg brake_cfg_ff;
  reg [VW-1:0] ramp_ff;
  reg [VW-1:0] win_ff;
  reg err_ff;
  reg step_d_ff;
  wire pause_s;
  wire stop_s;
  wire step_s;
  wire dir_s;
  wire [NOUT-1:0] fn_val;

  // Pins are asynchronous to pclk
  dio_sync u_sync_pause (.pclk(pclk), .presetn(presetn), .din(pause_in), .dout(pause_s));
  dio_sync u_sync_stop (.pclk(pclk), .presetn(presetn), .din(op_stop_in), .dout(stop_s));
  dio_sync u_sync_step (.pclk(pclk), .presetn(presetn), .din(pulse_step), .dout(step_s));
  dio_sync u_sync_dir (.pclk(pclk), .presetn(presetn), .din(pulse_dir), .dout(dir_s));

  // Status conditions
  wire standstill;
  wire movement_completed;
  wire motion_done;
  wire speed_reached;
  wire [VW-1:0] vel_diff;
  wire pause_active;
  assign standstill = (velocity == {VW{1'b0}});
  assign movement_completed = pos_in_tol && standstill && pulse_mode_ff; // R19
  assign motion_done = data_set_done && movement_completed; // R3 R18
  assign vel_diff = (velocity > target_velocity) ? (velocity - target_velocity)
                                                 : (target_velocity - velocity);
  assign speed_reached = (vel_diff <= win_ff); // R4
  assign pause_active = pause_s && pulse_mode_ff; // R6

  // One selector per output
  genvar gi;
  generate
    for (gi = 0; gi < NOUT; gi = gi + 1) begin : g_out
      dio_outsel u_sel (
        .sel(sel_ff[8*gi+7:8*gi]), // R1
        .capture_done(capture_ok),
        .data_set_done(data_set_done),
        .movement_completed(movement_completed),
        .motion_done(motion_done),
        .speed_reached(speed_reached),
        .soft_output_word(soft_output_word_ff),
        .value(fn_val[gi])
      );
    end
  endgenerate

  // Straight registering, no filter, so outputs lag functions by one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= {NOUT{1'b0}};
    end else begin
      dout <= fn_val; // R21
    end
  end

  // Stop state machine, one-hot
  localparam ST_RUN = 4'b0001;
  localparam ST_PAUSE = 4'b0010;
  localparam ST_STOPDEC = 4'b0100;
  localparam ST_OFF = 4'b1000;
  // State register is written in the motion process below
  reg [3:0] st_ff;
  reg [3:0] nxt_st;
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_RUN: begin
        if (stop_s) begin
          nxt_st = ST_STOPDEC; // R12
        end else if (pause_active) begin
          nxt_st = ST_PAUSE; // R7
        end
      end
      ST_PAUSE: begin
        if (stop_s) begin
          nxt_st = ST_STOPDEC;
        end else if (!pause_active) begin
          nxt_st = ST_RUN; // R8
        end
      end
      ST_STOPDEC: begin
        if (speed_cmd == {VW{1'b0}} && standstill) begin
          nxt_st = ST_OFF; // R14
        end
      end
      ST_OFF: begin
        nxt_st = ST_OFF; // Left only by software re-enable
      end
      default: begin
        nxt_st = ST_RUN;
      end
    endcase
  end

  // APB decode; one wait state, unmapped addresses answer with pslverr
  wire apb_acc;
  wire apb_wr;
  reg hit;
  reg [31:0] rdata;
  assign apb_acc = psel && penable && !pready;
  assign apb_wr = apb_acc && pwrite;
  wire reenable;
  assign reenable = apb_wr && (paddr == `DIO_REG_CTRL) && pwdata[`DIO_CTRL_ENABLE];

  // Read mux for the addressed register
  always @* begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      `DIO_REG_SEL0: rdata = sel_ff[31:0];
      `DIO_REG_SEL1: rdata = {{(64-8*NOUT){1'b0}}, sel_ff[8*NOUT-1:32]};
      `DIO_REG_SOFT: rdata = {24'h00_0000, soft_output_word_ff};
      `DIO_REG_CTRL: rdata = {29'h0000_0000, power_enable, brake_cfg_ff, pulse_mode_ff};
      `DIO_REG_RAMP: rdata = {{(32-VW){1'b0}}, ramp_ff};
      `DIO_REG_WIN: rdata = {{(32-VW){1'b0}}, win_ff};
      `DIO_REG_STAT: rdata = {27'h000_0000, err_ff, brake_apply, power_enable,
                              (st_ff == ST_STOPDEC || st_ff == ST_OFF),
                              (st_ff == ST_PAUSE)};
      `DIO_REG_ERR: rdata = {24'h00_0000, op_stop_error_code};
      default: hit = 1'b0;
    endcase
  end

  // Register writes and the one-cycle APB answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      sel_ff <= {(8*NOUT){1'b0}};
      soft_output_word_ff <= 8'h00;
      pulse_mode_ff <= 1'b0;
      brake_cfg_ff <= 1'b0;
      ramp_ff <= `DIO_RAMP_RESET;
      win_ff <= `DIO_WIN_RESET;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc && !hit;
      prdata <= (apb_acc && !pwrite) ? rdata : 32'h0000_0000;
      if (apb_wr) begin
        case (paddr)
          `DIO_REG_SEL0: sel_ff[31:0] <= pwdata;
          `DIO_REG_SEL1: sel_ff[8*NOUT-1:32] <= pwdata[8*NOUT-33:0];
          `DIO_REG_SOFT: soft_output_word_ff <= pwdata[7:0];
          `DIO_REG_CTRL: begin
            pulse_mode_ff <= pwdata[`DIO_CTRL_PULSE_MODE];
            brake_cfg_ff <= pwdata[`DIO_CTRL_BRAKE];
          end
          `DIO_REG_RAMP: ramp_ff <= pwdata[VW-1:0]; // R13
          `DIO_REG_WIN: win_ff <= pwdata[VW-1:0];
          default: ; // Unmapped writes are dropped
        endcase
      end
    end
  end

  // Motion: ramp generator and pulse counting
  wire decel;
  wire accept_pulse;
  assign decel = (st_ff != ST_RUN);
  assign accept_pulse = (st_ff == ST_RUN) && !pause_active; // R9 R10

  // Rising edge of the synchronised step pin; direction settles before it
  wire step_rise;
  assign step_rise = step_s && !step_d_ff;

  // Stop request seen in a moving state; flags the error once per stop
  wire stop_entry;
  assign stop_entry = stop_s && (st_ff == ST_RUN || st_ff == ST_PAUSE);

  // Standstill reached inside the stop ramp: power stage goes off
  wire power_off_evt;
  assign power_off_evt = (st_ff == ST_STOPDEC) && (nxt_st == ST_OFF);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RUN;
      step_d_ff <= 1'b0;
      target_pos <= 32'h0000_0000;
      speed_cmd <= {VW{1'b0}};
      power_enable <= 1'b1;
      brake_apply <= 1'b0;
      err_ff <= 1'b0;
      op_stop_error_code <= 8'h00;
    end else begin
      step_d_ff <= step_s;
      // Discarded pulses never reach target, so release resumes from the hold point
      if (step_rise && accept_pulse) begin
        target_pos <= dir_s ? target_pos - 32'h0000_0001 : target_pos + 32'h0000_0001; // R10
      end
      // Both stop kinds share one ramp step
      if (decel) begin
        speed_cmd <= (speed_cmd > ramp_ff) ? speed_cmd - ramp_ff : {VW{1'b0}}; // R7 R12 R13
      end else begin
        speed_cmd <= target_velocity; // R8
      end
      if (power_off_evt) begin
        power_enable <= 1'b0; // R14
        brake_apply <= brake_cfg_ff; // R14
      end
      if (stop_entry) begin
        err_ff <= 1'b1; // R15
        op_stop_error_code <= `DIO_OPSTOP_ERR; // R15
      end
      // Re-enable is only honoured once the stop input is gone
      if (st_ff == ST_OFF && reenable && !stop_s) begin
        st_ff <= ST_RUN; // R16
        power_enable <= 1'b1;
        brake_apply <= 1'b0;
        err_ff <= 1'b0;
        op_stop_error_code <= 8'h00;
      end else begin
        st_ff <= nxt_st;
      end
    end
  end
endmodule // dio_top

/* rtl/dio_defines.vh */
`ifndef DIO_DEFINES_VH
`define DIO_DEFINES_VH
// Output function selection codes
`define DIO_SEL_DATA_SET 8'h15
`define DIO_SEL_MOVE_DONE 8'h05
`define DIO_SEL_CAPTURE 8'h16
`define DIO_SEL_MOTION 8'h17
`define DIO_SEL_SPEED 8'h19
`define DIO_SEL_SOFT_BASE 8'h30
`define DIO_SEL_SOFT_LAST 8'h37
// Register byte offsets
`define DIO_REG_SEL0 12'h000
`define DIO_REG_SEL1 12'h004
`define DIO_REG_SOFT 12'h008
`define DIO_REG_CTRL 12'h00c
`define DIO_REG_RAMP 12'h010
`define DIO_REG_WIN 12'h014
`define DIO_REG_STAT 12'h018
`define DIO_REG_ERR 12'h01c
// Control register bits
`define DIO_CTRL_PULSE_MODE 0
`define DIO_CTRL_BRAKE 1
`define DIO_CTRL_ENABLE 2
// Status register bits
`define DIO_STAT_PAUSE 0
`define DIO_STAT_OPSTOP 1
`define DIO_STAT_POWER 2
`define DIO_STAT_BRAKE 3
`define DIO_STAT_ERR 4
// Error code reported by an operational stop; value arbitrary
`define DIO_OPSTOP_ERR 8'h0d
`define DIO_RAMP_RESET 16'h0010
`define DIO_WIN_RESET 16'h0010
`endif

/* rtl/dio_sync.v */
`timescale 1ns/1ps
// Three-stage input synchroniser; a change counts when stages two and three agree
module dio_sync (
  pclk,
  presetn,
  din,
  dout
);
  input wire pclk;
  input wire presetn;
  input wire din;
  output reg dout;
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  // Stage one feeds stage two only, to keep metastability contained
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout <= s3_ff;
      end
    end
  end
endmodule // dio_sync

/* rtl/dio_outsel.v */
`timescale 1ns/1ps
`include "dio_defines.vh"
// Combinational function selector for one digital output
module dio_outsel (
  sel,
  capture_done,
  data_set_done,
  movement_completed,
  motion_done,
  speed_reached,
  soft_output_word,
  value
);
  input wire [7:0] sel;
  input wire capture_done;
  input wire data_set_done;
  input wire movement_completed;
  input wire motion_done;
  input wire speed_reached;
  input wire [7:0] soft_output_word;
  output reg value;
  wire [7:0] soft_idx;
  assign soft_idx = sel - `DIO_SEL_SOFT_BASE;
  // Reserved and unsupported codes fall to inactive
  always @* begin
    value = 1'b0; // R20
    if (sel == `DIO_SEL_DATA_SET) begin
      value = data_set_done; // R18
    end else if (sel == `DIO_SEL_MOVE_DONE) begin
      value = movement_completed; // R19
    end else if (sel == `DIO_SEL_CAPTURE) begin
      value = capture_done; // R2
    end else if (sel == `DIO_SEL_MOTION) begin
      value = motion_done; // R3
    end else if (sel == `DIO_SEL_SPEED) begin
      value = speed_reached; // R4
    end else if (sel >= `DIO_SEL_SOFT_BASE && sel <= `DIO_SEL_SOFT_LAST) begin
      value = soft_output_word[soft_idx[2:0]]; // R5
    end
  end
endmodule // dio_outsel

/* tb/dio_ctrl_model.sv */
`timescale 1ns/1ps
module dio_ctrl_model (
  input wire pclk,
  input wire presetn,
  input wire go,
  input wire [7:0] n_req,
  output wire pulse_step,
  output wire pulse_dir,
  output wire busy
);
  reg [7:0] left_ff;
  reg [2:0] ph_ff;
  // Steps are four cycles high and four low, slow enough for the pin synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_ff <= 8'h00;
      ph_ff <= 3'h0;
    end else if (go && left_ff == 8'h00) begin
      left_ff <= n_req;
      ph_ff <= 3'h0;
    end else if (left_ff != 8'h00) begin
      ph_ff <= ph_ff + 3'h1;
      if (ph_ff == 3'h7) left_ff <= left_ff - 8'h01;
    end
  end
  assign busy = (left_ff != 8'h00);
  assign pulse_step = busy && !ph_ff[2];
  assign pulse_dir = 1'b0; // One direction; the bench compares step magnitude only
endmodule // dio_ctrl_model

/* tb/dio_top_asserts.sv */
`timescale 1ns/1ps
`include "dio_defines.vh"
module dio_top_asserts #(
  parameter NOUT = 5,
  parameter VW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pause_in,
  input wire op_stop_in,
  input wire [VW-1:0] velocity,
  input wire [VW-1:0] speed_cmd,
  input wire [31:0] target_pos,
  input wire power_enable,
  input wire brake_apply,
  input wire [7:0] op_stop_error_code
);
  reg [1:0] mode_ff;
  // Mirror mode and brake bits; one cycle late, which only makes the checks looser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_ff <= 2'h0;
    else if (psel && penable && pready && pwrite && paddr == `DIO_REG_CTRL) mode_ff <= pwdata[1:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rest; $fell(power_enable) |-> $past(velocity) == 0 && speed_cmd == 0; endproperty
  a_rest: assert property (p_rest) else $error("power dropped while moving");
  property p_brake_off; brake_apply |-> !power_enable; endproperty
  a_brake_off: assert property (p_brake_off) else $error("brake on with power");
  property p_brake_cfg; $rose(brake_apply) |-> mode_ff[1]; endproperty
  a_brake_cfg: assert property (p_brake_cfg) else $error("brake not configured");
  property p_code;
    op_stop_error_code != 8'h00 |-> op_stop_error_code == `DIO_OPSTOP_ERR;
  endproperty
  a_code: assert property (p_code) else $error("wrong error code");
  property p_err_off;
    $fell(power_enable) |-> ##[0:1] op_stop_error_code == `DIO_OPSTOP_ERR;
  endproperty
  a_err_off: assert property (p_err_off) else $error("stop without error code");
  property p_stop_ramp; op_stop_in [*6] |=> speed_cmd <= $past(speed_cmd); endproperty
  a_stop_ramp: assert property (p_stop_ramp) else $error("speed rose in stop");
  property p_pause_ramp;
    (mode_ff[0] && pause_in) [*6] |=> speed_cmd <= $past(speed_cmd);
  endproperty
  a_pause_ramp: assert property (p_pause_ramp) else $error("speed rose in pause");
  property p_pause_hold; (mode_ff[0] && pause_in) [*8] |=> $stable(target_pos); endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pulse counted in pause");
endmodule // dio_top_asserts
bind dio_top dio_top_asserts #(.NOUT(NOUT), .VW(VW)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pause_in, .op_stop_in, .velocity, .speed_cmd, .target_pos,
  .power_enable, .brake_apply, .op_stop_error_code);

/* tb/test_drive_io_function_stop_logic.sv */
`timescale 1ns/1ps
`include "dio_defines.vh"
module test_drive_io_function_stop_logic;
  localparam [39:0] RSV = 40'h181a2f383f;
  localparam [7:0] SW = 8'ha5;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pause_in = 1'b0, op_stop_in = 1'b0;
  reg capture_ok = 1'b0, data_set_done = 1'b0, pos_in_tol = 1'b0, go = 1'b0, err;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd, p0;
  reg [15:0] velocity = 16'h0, target_velocity = 16'h0, s;
  reg [7:0] n_req = 8'h00;
  wire [31:0] prdata, target_pos;
  wire [15:0] speed_cmd;
  wire [7:0] op_stop_error_code;
  wire [4:0] dout;
  wire pready, pslverr, pulse_step, pulse_dir, power_enable, brake_apply, busy;
  integer bad_count = 0, n_compared = 0, cyc = 0;
  dio_top #(.NOUT(5), .VW(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pause_in, .op_stop_in, .pulse_step, .pulse_dir, .capture_ok,
    .data_set_done, .pos_in_tol, .velocity, .target_velocity, .dout, .speed_cmd, .target_pos,
    .power_enable, .brake_apply, .op_stop_error_code);
  dio_ctrl_model u_ctrl (.pclk, .presetn, .go, .n_req, .pulse_step, .pulse_dir, .busy);
  always #2 pclk = ~pclk;
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      bad_count = bad_count + 1;
      finish_test;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  // One transfer; an idle edge at the end keeps back-to-back calls from colliding
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wsel(input [7:0] c);
    begin
      apb(1'b1, `DIO_REG_SEL0, {4{c}});
      apb(1'b1, `DIO_REG_SEL1, {24'h0, c});
    end
  endtask
  task send(input [7:0] n);
    begin
      n_req <= n;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      wt(2);
      while (busy) @(posedge pclk);
      wt(6);
    end
  endtask
  function [31:0] dlt(input [31:0] a, input [31:0] b);
    dlt = (a > b) ? a - b : b - a;
  endfunction
  task t_regs;
    begin
      apb(1'b0, `DIO_REG_RAMP, 32'h0);
      chk(rd, 32'h10);
      apb(1'b0, `DIO_REG_CTRL, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, 12'h020, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      $display("regs done");
    end
  endtask
  task t_soft;
    integer n;
    begin
      apb(1'b1, `DIO_REG_SOFT, {24'h0, SW});
      for (n = 0; n < 8; n = n + 1) begin
        wsel(8'h30 + n[7:0]);
        chk(dout, {27'h0, {5{SW[n]}}});
      end
      apb(1'b1, `DIO_REG_SOFT, 32'hff);
      for (n = 0; n < 5; n = n + 1) begin
        wsel(RSV[8*n +: 8]);
        chk(dout, 32'h0);
      end
      $display("soft done");
    end
  endtask
  task t_funcs;
    begin
      apb(1'b1, `DIO_REG_SEL0, 32'h19171615);
      apb(1'b1, `DIO_REG_SEL1, 32'h05);
      apb(1'b1, `DIO_REG_CTRL, 32'h1);
      capture_ok <= 1'b1;
      data_set_done <= 1'b1;
      pos_in_tol <= 1'b1;
      wt(2);
      chk(dout, 32'h1f);
      velocity <= 16'h0011;
      wt(2);
      chk(dout, 32'h03);
      velocity <= 16'h0010;
      wt(2);
      chk(dout, 32'h0b);
      apb(1'b1, `DIO_REG_CTRL, 32'h0);
      velocity <= 16'h0000;
      capture_ok <= 1'b0;
      wt(2);
      chk(dout, 32'h09);
      $display("funcs done");
    end
  endtask
  task t_pause;
    begin
      target_velocity <= 16'h0040;
      pause_in <= 1'b1;
      wt(6);
      chk(speed_cmd, 32'h40);
      p0 = target_pos;
      send(8'h05);
      chk(dlt(target_pos, p0), 32'h5);
      apb(1'b1, `DIO_REG_CTRL, 32'h1);
      wt(10);
      chk(speed_cmd, 32'h0);
      p0 = target_pos;
      send(8'h05);
      chk(dlt(target_pos, p0), 32'h0);
      pause_in <= 1'b0;
      wt(8);
      chk(speed_cmd, 32'h40);
      p0 = target_pos;
      send(8'h03);
      chk(dlt(target_pos, p0), 32'h3);
      $display("pause done");
    end
  endtask
  task t_stop;
    begin
      target_velocity <= 16'h0020;
      apb(1'b1, `DIO_REG_RAMP, 32'h8);
      apb(1'b1, `DIO_REG_CTRL, 32'h3);
      op_stop_in <= 1'b1;
      while (speed_cmd === 16'h0020) @(posedge pclk);
      s = speed_cmd;
      @(posedge pclk);
      chk(s - speed_cmd, 32'h8);
      wt(20);
      chk(speed_cmd, 32'h0);
      chk(power_enable, 32'h0);
      chk(brake_apply, 32'h1);
      chk(op_stop_error_code, 32'h0d);
      apb(1'b0, `DIO_REG_STAT, 32'h0);
      chk(rd, 32'h1a);
      apb(1'b0, `DIO_REG_ERR, 32'h0);
      chk(rd, 32'h0d);
      apb(1'b1, `DIO_REG_CTRL, 32'h7);
      chk(power_enable, 32'h0);
      op_stop_in <= 1'b0;
      wt(6);
      apb(1'b1, `DIO_REG_CTRL, 32'h7);
      chk(power_enable, 32'h1);
      $display("stop done");
    end
  endtask
  task finish_test;
    begin
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    wt(10);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_soft;
    t_funcs;
    t_pause;
    t_stop;
    finish_test;
  end
endmodule // test_drive_io_function_stop_logic
